// file: core/gdr_pkg.sv
package gdr_pkg;

	localparam int REG_IDX_W = 3;

	// register indices on the message port
	localparam logic [2:0] IDX_CONFIG_REGISTER_ZERO    = 3'h0;
	localparam logic [2:0] IDX_DAC     = 3'h1;
	localparam logic [2:0] IDX_TIMING  = 3'h2;
	localparam logic [2:0] IDX_STATUS0 = 3'h3;
	localparam logic [2:0] IDX_STATUS1 = 3'h4;

	// reset values
	localparam logic [7:0] RST_CONFIG_REGISTER_ZERO   = 8'h00;
	localparam logic [7:0] RST_DAC    = 8'h40;
	localparam logic [7:0] RST_TIMING = 8'h00;

	// field positions and masks
	localparam logic [7:0] MASK_CONFIG_REGISTER_ZERO   = 8'h7f;
	localparam logic [7:0] MASK_TIMING = 8'h1f;
	localparam int CONFIG_REGISTER_ZERO_OCL_LSB  = 0;
	localparam int CONFIG_REGISTER_ZERO_SCD_BIT  = 2;
	localparam int TIM_DT_LSB    = 2;
	localparam int TIM_BL_LSB    = 0;
	localparam int ST1_LDO5_BIT  = 5;
	localparam int ST1_LOST_BIT  = 4;
	localparam int ST1_XOC_BIT   = 3;
	localparam int ST1_GDUV_BIT  = 2;

	// timing figures
	localparam int CLK_PERIOD_NS = 10;
	localparam int DT_MAX_NS     = 2000;
	localparam int DT_STEP_NS    = 250;
	localparam int BL_MAX_NS     = 4000;
	localparam int CYC_W         = 12;

	// analog figures in microvolts / millivolts
	localparam int DAC_ZERO_UV   = 991000;
	localparam int DAC_SPAN_UV   = 3512000;
	localparam int DAC_CODE_MAX  = 255;
	localparam int OCL_STEP_MV   = 250;
	localparam int UV_W          = 23;
	localparam int MV_W          = 11;

	// monitored conditions, status0 bit order from bit 7 down
	typedef struct packed {
		logic buck_uv_fault;
		logic buck_uv_warning;
		logic buck_input_overcurrent_warning;
		logic supply_overvoltage_fault;
		logic driver_supply_overvoltage_fault;
		logic supply_undervoltage_fault;
		logic overtemp_fault;
		logic overtemp_warning;
		logic ldo5_undervoltage;
		logic ext_fet_overcurrent_fault;
		logic gate_drive_undervoltage_fault;
	} gdr_cond_t;

	localparam int COND_W = 11;

endpackage

// file: core/gdr_regs.sv
module gdr_regs
	import gdr_pkg::*;
#(
	parameter bit HAS_DRIVER_OV_MONITOR = 1'b1
) (
	input  wire logic                   ref_clk,
	input  wire logic                   arst_n,
	input  wire logic                   cfg_wr,
	input  wire logic [REG_IDX_W-1:0]   cfg_idx,
	input  wire logic [7:0]             cfg_wdata,
	input  wire logic [REG_IDX_W-1:0]   rd_idx,
	output logic      [7:0]             rd_data,
	input  wire gdr_pkg::gdr_cond_t     cond_pins,
	input  wire logic                   internal_reset_pin,
	output logic      [7:0]             threshold_code,
	output logic      [UV_W-1:0]        threshold_uv,
	output logic      [2:0]             dead_time_select,
	output logic      [1:0]             blanking_select,
	output logic      [CYC_W-1:0]       dead_time_cycles,
	output logic      [CYC_W-1:0]       blanking_cycles,
	output logic      [1:0]             overcurrent_limit_select,
	output logic      [MV_W-1:0]        overcurrent_limit_mv,
	output logic                        short_circuit_detect_disable,
	output logic                        config_lost_flag
);
	import gdr_pkg::*;

	logic             rst_meta;
	logic             rst_n;
	logic [7:0]       config_register_zero;
	logic [7:0]       overcurrent_dac_reference;
	logic [7:0]       driver_timing_config;
	logic [7:0]       next_config_register_zero;
	logic [7:0]       next_dac;
	logic [7:0]       next_timing;
	logic             next_lost;
	logic [7:0]       next_rd_data;
	logic [7:0]       supply_thermal_status;
	logic [7:0]       driver_fault_status;
	logic [UV_W-1:0]  next_threshold_uv;
	logic [MV_W-1:0]  next_ocl_mv;
	logic [COND_W-1:0] cond_sync_bits;
	gdr_cond_t        cond;
	logic             ireset_sync;
	logic             ireset_prev;
	logic             ireset_rise;
	logic             cfg_accept;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// conditions come from analog comparators, so every one is synchronised
	gdr_sync #(
		.W (COND_W)
	) u_cond_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.din     (cond_pins),
		.dout    (cond_sync_bits)
	);

	assign cond = gdr_cond_t'(cond_sync_bits);

	gdr_sync #(
		.W (1)
	) u_ireset_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.din     (internal_reset_pin),
		.dout    (ireset_sync)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ireset_prev <= 1'b0;
		end else begin
			ireset_prev <= ireset_sync;
		end
	end

	assign ireset_rise = ireset_sync & ~ireset_prev;

	function automatic logic is_cfg_idx(input logic [REG_IDX_W-1:0] idx);
		return (idx == IDX_CONFIG_REGISTER_ZERO) || (idx == IDX_DAC) || (idx == IDX_TIMING);
	endfunction

	// only configuration indices accept a write; status writes fall away
	assign cfg_accept = cfg_wr & is_cfg_idx(cfg_idx);

	always_comb begin
		next_config_register_zero   = config_register_zero;
		next_dac    = overcurrent_dac_reference;
		next_timing = driver_timing_config;
		if (cfg_wr) begin
			unique case (cfg_idx)
				IDX_CONFIG_REGISTER_ZERO: begin
					next_config_register_zero = cfg_wdata & MASK_CONFIG_REGISTER_ZERO;
				end
				IDX_DAC: begin
					next_dac = cfg_wdata;
				end
				IDX_TIMING: begin
					next_timing = cfg_wdata & MASK_TIMING;
				end
				default: begin
					next_config_register_zero = config_register_zero;
				end
			endcase
		end
	end

	// set wins over clear, so a reset landing with a write is not lost
	always_comb begin
		next_lost = config_lost_flag;
		if (cfg_accept) begin
			next_lost = 1'b0;
		end
		if (ireset_rise) begin
			next_lost = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			config_register_zero      <= RST_CONFIG_REGISTER_ZERO;
			overcurrent_dac_reference <= RST_DAC;
			driver_timing_config      <= RST_TIMING;
			config_lost_flag          <= 1'b1;
		end else begin
			config_register_zero      <= next_config_register_zero;
			overcurrent_dac_reference <= next_dac;
			driver_timing_config      <= next_timing;
			config_lost_flag          <= next_lost;
		end
	end

	always_comb begin
		supply_thermal_status = {
			cond.buck_uv_fault,
			cond.buck_uv_warning,
			cond.buck_input_overcurrent_warning,
			cond.supply_overvoltage_fault,
			cond.driver_supply_overvoltage_fault
				& HAS_DRIVER_OV_MONITOR,
			cond.supply_undervoltage_fault,
			cond.overtemp_fault,
			cond.overtemp_warning
		};
		driver_fault_status = 8'h00;
		driver_fault_status[ST1_LDO5_BIT] = cond.ldo5_undervoltage;
		driver_fault_status[ST1_LOST_BIT] = config_lost_flag;
		// raw comparator result; host gates it per the detect bit
		driver_fault_status[ST1_XOC_BIT] =
			cond.ext_fet_overcurrent_fault;
		driver_fault_status[ST1_GDUV_BIT] =
			cond.gate_drive_undervoltage_fault;
	end

	always_comb begin
		unique case (rd_idx)
			IDX_CONFIG_REGISTER_ZERO:    next_rd_data = config_register_zero;
			IDX_DAC:     next_rd_data = overcurrent_dac_reference;
			IDX_TIMING:  next_rd_data = driver_timing_config;
			IDX_STATUS0: next_rd_data = supply_thermal_status;
			IDX_STATUS1: next_rd_data = driver_fault_status;
			default:     next_rd_data = 8'h00;
		endcase
	end

	// linear threshold in microvolts for the dac model downstream
	always_comb begin
		next_threshold_uv = UV_W'(DAC_ZERO_UV
			+ (int'(overcurrent_dac_reference) * DAC_SPAN_UV)
			/ DAC_CODE_MAX);
		next_ocl_mv = MV_W'(OCL_STEP_MV
			* (int'(config_register_zero[CONFIG_REGISTER_ZERO_OCL_LSB +: 2]) + 1));
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data                      <= 8'h00;
			threshold_code               <= RST_DAC;
			threshold_uv                 <= '0;
			dead_time_select             <= 3'h0;
			blanking_select              <= 2'h0;
			overcurrent_limit_select     <= 2'h0;
			overcurrent_limit_mv         <= '0;
			short_circuit_detect_disable <= 1'b0;
		end else begin
			rd_data                      <= next_rd_data;
			threshold_code               <= overcurrent_dac_reference;
			threshold_uv                 <= next_threshold_uv;
			dead_time_select             <=
				driver_timing_config[TIM_DT_LSB +: 3];
			blanking_select              <=
				driver_timing_config[TIM_BL_LSB +: 2];
			overcurrent_limit_select     <=
				config_register_zero[CONFIG_REGISTER_ZERO_OCL_LSB +: 2];
			overcurrent_limit_mv         <= next_ocl_mv;
			// one means detection off
			short_circuit_detect_disable <=
				config_register_zero[CONFIG_REGISTER_ZERO_SCD_BIT];
		end
	end

	gdr_timing_decode u_timing (
		.ref_clk          (ref_clk),
		.rst_n            (rst_n),
		.dead_time_select (driver_timing_config[TIM_DT_LSB +: 3]),
		.blanking_select  (driver_timing_config[TIM_BL_LSB +: 2]),
		.dead_time_cycles (dead_time_cycles),
		.blanking_cycles  (blanking_cycles)
	);
endmodule

// file: core/gdr_sync.sv
module gdr_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta;

	// meta is read only by dout
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// file: core/gdr_timing_decode.sv
module gdr_timing_decode
	import gdr_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [2:0]       dead_time_select,
	input  wire logic [1:0]       blanking_select,
	output logic      [CYC_W-1:0] dead_time_cycles,
	output logic      [CYC_W-1:0] blanking_cycles
);
	logic [CYC_W-1:0] next_dead_time_cycles;
	logic [CYC_W-1:0] next_blanking_cycles;

	always_comb begin
		next_dead_time_cycles = CYC_W'((DT_MAX_NS
			- DT_STEP_NS * int'(dead_time_select)) / CLK_PERIOD_NS);
		next_blanking_cycles = CYC_W'((BL_MAX_NS
			>> blanking_select) / CLK_PERIOD_NS);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dead_time_cycles <= CYC_W'(DT_MAX_NS / CLK_PERIOD_NS);
			blanking_cycles  <= CYC_W'(BL_MAX_NS / CLK_PERIOD_NS);
		end else begin
			dead_time_cycles <= next_dead_time_cycles;
			blanking_cycles  <= next_blanking_cycles;
		end
	end
endmodule

// file: sim/gate_driver_cfg_status_regs_test.sv
module gate_driver_cfg_status_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	import gdr_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic irst = 1'b0;
	gdr_cond_t cond_pins = '0;
	logic cfg_wr, sc_dis, lost;
	logic [2:0] cfg_idx, rd_idx, dt_sel;
	logic [7:0] cfg_wdata, rd_data, thr, d;
	logic [1:0] bl_sel, ocl_sel;
	logic [UV_W-1:0] thr_uv;
	logic [CYC_W-1:0] dt_cyc, bl_cyc;
	logic [MV_W-1:0] ocl_mv;
	int mismatches = 0;
	int n_compared = 0;
	int i;
	always #5 ref_clk = ~ref_clk;
	gdr_host host (.ref_clk, .rd_data, .cfg_wr, .cfg_idx, .cfg_wdata,
		.rd_idx);
	gdr_regs dut (.ref_clk, .arst_n, .cfg_wr, .cfg_idx, .cfg_wdata,
		.rd_idx, .rd_data, .cond_pins, .internal_reset_pin(irst),
		.threshold_code(thr), .threshold_uv(thr_uv),
		.dead_time_select(dt_sel), .blanking_select(bl_sel),
		.dead_time_cycles(dt_cyc), .blanking_cycles(bl_cyc),
		.overcurrent_limit_select(ocl_sel),
		.overcurrent_limit_mv(ocl_mv),
		.short_circuit_detect_disable(sc_dis), .config_lost_flag(lost));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task rdc(input logic [2:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk("rd_data", d, e);
	endtask
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#100us;
		mismatches++;
		finish_test;
	end
	initial begin
		repeat (8) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		rdc(IDX_DAC, 8'h40);
		chk("thr_uv", thr_uv, DAC_ZERO_UV + 64 * DAC_SPAN_UV / 255);
		rdc(IDX_STATUS1, 8'h10);
		chk("lost", lost, 1);
		rdc(3'h5, 8'h00);
		for (i = 0; i < 32; i++) begin
			host.wr(IDX_TIMING, 8'he0 | 8'(i));
			rdc(IDX_TIMING, 8'(i));
			chk("dt", dt_cyc, (DT_MAX_NS - DT_STEP_NS * (i >> 2)) / 10);
			chk("bl", bl_cyc, (BL_MAX_NS >> (i & 3)) / 10);
			chk("dt_sel", dt_sel, i >> 2);
			chk("bl_sel", bl_sel, i & 3);
		end
		rdc(IDX_STATUS1, 8'h00);
		for (i = 0; i < 256; i += 255) begin
			host.wr(IDX_DAC, 8'(i));
			rdc(IDX_DAC, 8'(i));
			chk("thr_uv", thr_uv, DAC_ZERO_UV + i * DAC_SPAN_UV / 255);
			chk("thr", thr, i);
		end
		for (i = 0; i < 4; i++) begin
			host.wr(IDX_CONFIG_REGISTER_ZERO, 8'hf8 | 8'(i) | 8'(4 * (i & 1)));
			rdc(IDX_CONFIG_REGISTER_ZERO, 8'h78 | 8'(i) | 8'(4 * (i & 1)));
			chk("ocl", ocl_mv, OCL_STEP_MV * (i + 1));
			chk("ocl_sel", ocl_sel, i);
			chk("sc", sc_dis, i & 1);
		end
		for (i = 0; i < COND_W; i++) begin
			cond_pins = gdr_cond_t'(11'h1 << i);
			repeat (4) @(negedge ref_clk);
			rdc(IDX_STATUS0, 8'((11'h1 << i) >> 3));
			rdc(IDX_STATUS1,
				i == 2 ? 8'h20 : i < 2 ? 8'h04 << i : 8'h00);
			if (i == 1) begin
				chk("fet", host.fet_fault(d, 8'h7f), 1);
				chk("fet_off", host.fet_fault(d, 8'h7b), 0);
			end
		end
		cond_pins = '0;
		irst = 1'b1;
		repeat (2) @(negedge ref_clk);
		irst = 1'b0;
		repeat (4) @(negedge ref_clk);
		rdc(IDX_STATUS1, 8'h10);
		// status writes must neither land nor clear the lost flag
		host.wr(IDX_STATUS0, 8'hff);
		host.wr(IDX_STATUS1, 8'hff);
		repeat (4) @(negedge ref_clk);
		rdc(IDX_STATUS0, 8'h00);
		rdc(IDX_STATUS1, 8'h10);
		host.wr(IDX_DAC, 8'h12);
		rdc(IDX_STATUS1, 8'h00);
		chk("lost", lost, 0);
		// short reset in mid-run brings back the power-on values
		arst_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		rdc(IDX_DAC, 8'h40);
		rdc(IDX_TIMING, 8'h00);
		rdc(IDX_STATUS1, 8'h10);
		chk("ocl", ocl_mv, OCL_STEP_MV);
		chk("sc", sc_dis, 0);
		finish_test;
	end
endmodule
bind gdr_regs gdr_regs_chk chk (.ref_clk, .arst_n, .cfg_wr, .cfg_idx,
	.rd_idx, .rd_data, .cond_pins, .internal_reset_pin, .threshold_code,
	.threshold_uv, .dead_time_select, .blanking_select, .dead_time_cycles,
	.blanking_cycles, .overcurrent_limit_select, .overcurrent_limit_mv,
	.config_lost_flag);

// file: sim/gdr_host.sv
module gdr_host (
	input  wire logic       ref_clk,
	input  wire logic [7:0] rd_data,
	output logic            cfg_wr,
	output logic [2:0]      cfg_idx,
	output logic [7:0]      cfg_wdata,
	output logic [2:0]      rd_idx
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cfg_wr = 1'b0;
		cfg_idx = 3'h0;
		cfg_wdata = 8'h00;
		rd_idx = 3'h0;
	end
	task automatic wr(input logic [2:0] i, input logic [7:0] v);
		@(negedge ref_clk);
		cfg_idx = i;
		cfg_wdata = v;
		cfg_wr = 1'b1;
		@(negedge ref_clk);
		cfg_wr = 1'b0;
		// idle data is not left looking valid
		cfg_wdata = ~v;
	endtask
	task automatic rd(input logic [2:0] i, output logic [7:0] v);
		@(negedge ref_clk);
		rd_idx = i;
		@(negedge ref_clk);
		v = rd_data;
	endtask
	// overcurrent flag is trusted only with the disable bit set
	function automatic logic fet_fault(logic [7:0] st1, logic [7:0] c0);
		return st1[3] & c0[2];
	endfunction
endmodule

// file: sim/gdr_regs_chk.sv
module gdr_regs_chk
	import gdr_pkg::*;
(
	input wire logic                 ref_clk,
	input wire logic                 arst_n,
	input wire logic                 cfg_wr,
	input wire logic [REG_IDX_W-1:0] cfg_idx,
	input wire logic [REG_IDX_W-1:0] rd_idx,
	input wire logic [7:0]           rd_data,
	input wire gdr_pkg::gdr_cond_t   cond_pins,
	input wire logic                 internal_reset_pin,
	input wire logic [7:0]           threshold_code,
	input wire logic [UV_W-1:0]      threshold_uv,
	input wire logic [2:0]           dead_time_select,
	input wire logic [1:0]           blanking_select,
	input wire logic [CYC_W-1:0]     dead_time_cycles,
	input wire logic [CYC_W-1:0]     blanking_cycles,
	input wire logic [1:0]           overcurrent_limit_select,
	input wire logic [MV_W-1:0]      overcurrent_limit_mv,
	input wire logic                 config_lost_flag
);
	logic [2:0] up_cnt;
	logic [2:0] next_up_cnt;

	// cycles since reset release; a short mid-run reset must not let
	// derived outputs be judged before they have caught up
	always_comb begin
		next_up_cnt = up_cnt;
		if (up_cnt != 3'h7) begin
			next_up_cnt = up_cnt + 3'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			up_cnt <= 3'h0;
		end else begin
			up_cnt <= next_up_cnt;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// pins pass two sync flops and the read register
	sequence s_hold(logic [2:0] i);
		(up_cnt >= 3'h5 && $stable(cond_pins) && rd_idx == i)[*3];
	endsequence
	sequence s_quiet;
		(up_cnt >= 3'h4 && !internal_reset_pin)[*5];
	endsequence
	dt_cycles_a: assert property (
		dead_time_cycles == CYC_W'((DT_MAX_NS - DT_STEP_NS
		* dead_time_select) / CLK_PERIOD_NS)) else $error("dead time");
	bl_cycles_a: assert property (
		blanking_cycles == CYC_W'((BL_MAX_NS >> blanking_select)
		/ CLK_PERIOD_NS)) else $error("blanking time");
	ocl_mv_a: assert property (
		up_cnt >= 3'h4 && $stable(overcurrent_limit_select) |->
		overcurrent_limit_mv == MV_W'(OCL_STEP_MV
		* (overcurrent_limit_select + 1))) else $error("limit mv");
	thr_uv_a: assert property (
		up_cnt >= 3'h4 && $stable(threshold_code) |->
		threshold_uv == UV_W'(DAC_ZERO_UV + threshold_code
		* DAC_SPAN_UV / DAC_CODE_MAX)) else $error("threshold uv");
	st0_read_a: assert property (
		s_hold(IDX_STATUS0) |-> rd_data == cond_pins[10:3])
		else $error("status0 value");
	st1_read_a: assert property (
		s_hold(IDX_STATUS1) |-> rd_data == {2'h0,
		cond_pins.ldo5_undervoltage, $past(config_lost_flag),
		cond_pins.ext_fet_overcurrent_fault,
		cond_pins.gate_drive_undervoltage_fault, 2'h0})
		else $error("status1 value");
	tim_rsv_a: assert property (
		$past(rd_idx) == IDX_TIMING |-> rd_data[7:5] == 3'h0)
		else $error("timing reserved bits");
	lost_clr_a: assert property (
		s_quiet ##0 (cfg_wr && cfg_idx < IDX_STATUS0) |=>
		!config_lost_flag) else $error("lost flag not cleared");
	lost_set_a: assert property (
		$rose(internal_reset_pin) |-> ##[2:4] config_lost_flag)
		else $error("lost flag not set");
endmodule
